// ---- core/pcm_consts.vh ----
// constants shared by the press contact sequence monitor files
`ifndef PCM_CONSTS_VH
`define PCM_CONSTS_VH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define PCM_ADDR_CTRL 32'h0000_0000
`define PCM_ADDR_STAT 32'h0000_0004
`define PCM_ADDR_MASK 32'h0000_00fc
`define PCM_CTRL_W 6
`define PCM_CTRL_RST 6'h00
`define PCM_STAT_W 13

// control field positions
`define PCM_C_RUN 0
`define PCM_C_CLREN 1
`define PCM_C_MODE02 2
`define PCM_C_MIN350 3
`define PCM_C_FLAGEN 4
`define PCM_C_OVREN 5

// ------------------------------------------------------------
// bus encodings
// ------------------------------------------------------------
`define PCM_HTRANS_BUSY_BIT 1
`define PCM_ZERO32 32'h0000_0000

// ------------------------------------------------------------
// synchroniser lanes
// ------------------------------------------------------------
`define PCM_NSYNC 5
`define PCM_S_UP 0
`define PCM_S_LO 1
`define PCM_S_OV 2
`define PCM_S_CLR 3
`define PCM_S_PRM 4
`define PCM_SYNC_RST 5'h00

// ------------------------------------------------------------
// lower contact edge counts per stroke
// ------------------------------------------------------------
`define PCM_CNT_ZERO 2'h0
`define PCM_CNT_ONE 2'h1
`define PCM_CNT_TWO 2'h2
`define PCM_CNT_MAX 2'h3

// ------------------------------------------------------------
// clear pulse timing (100 MHz logic clock)
// ------------------------------------------------------------
`define PCM_CYC_PER_MS 32'd100000
`define PCM_CLR_MIN_A_MS 32'd100
`define PCM_CLR_MIN_B_MS 32'd350
`define PCM_CLR_MAX_MS 32'd30000
`define PCM_CNT_W 32
`define PCM_CNT_RST 32'h0000_0000
`define PCM_CNT_ONE32 32'h0000_0001

`endif

// ---- core/pcm_sync.v ----
// two flip-flop synchroniser for the contact and pin inputs
`include "pcm_consts.vh"
`default_nettype none

module pcm_sync (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // asynchronous levels in, synchronised levels out
    input wire [`PCM_NSYNC-1:0] async_in,
    output reg [`PCM_NSYNC-1:0] sync_out
);

    // first stage, read only by the second stage
    reg [`PCM_NSYNC-1:0] meta_q;

    // ------------------------------------------------------------
    // two stage capture
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta_q <= `PCM_SYNC_RST;
            sync_out <= `PCM_SYNC_RST;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // pcm_sync

`default_nettype wire

// ---- core/pcm_clrpulse.v ----
// clear pulse high-time measurement and validation
`include "pcm_consts.vh"
`default_nettype none

module pcm_clrpulse (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // synchronised clear level and limits in cycles
    input wire level,
    input wire [`PCM_CNT_W-1:0] min_cyc,
    input wire [`PCM_CNT_W-1:0] max_cyc,
    // one-cycle pulse on an accepted low-high-low
    output reg valid
);

    reg [`PCM_CNT_W-1:0] cnt_q; // high cycles seen
    reg level_q; // previous sample

    // ------------------------------------------------------------
    // count high time, judge it at the falling edge
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_q <= `PCM_CNT_RST;
            level_q <= 1'b0;
            valid <= 1'b0;
        end
        else
        begin
            level_q <= level;
            valid <= 1'b0;
            if (level)
            begin
                // saturate just past the maximum so long pulses fail
                if (cnt_q <= max_cyc)
                    cnt_q <= cnt_q + `PCM_CNT_ONE32;
            end
            else
            begin
                cnt_q <= `PCM_CNT_RST;
                // falling edge: accept only inside the window
                if (level_q)
                    valid <= (cnt_q >= min_cyc) &&
                             (cnt_q <= max_cyc);
            end
        end
    end

endmodule // pcm_clrpulse

`default_nettype wire

// ---- core/pcm_monitor.v ----
// press contact sequence monitor with AHB-Lite control registers
//
// Overview of operation
// - overrun and upper both low: fault
// - optional clear input resets latched faults
// - clear pulse high time at least minimum
// - too short or over 30 s ignored
// - bottom arrival: lower rises while upper high
// - one-edge mode: exactly one lower rise
// - out-of-order contact edges give sequence fault
// - 0-2 mode allows up to two rises
// - 0-2 mode: first rise sets upstroke
// - first lower fall drops upstroke, no re-set
// - one-edge mode: rise near 180 deg, upstroke
// - optional flag output on any fault
// - option enables overrun contact and checks
// - sequence fault drops permit, needs clear
// - drive late at overrun end: overrun fault
// - permit input low holds permit, pauses checks
// - lower high at start blanks first upstroke
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`include "pcm_consts.vh"
`default_nettype none

module pcm_monitor #(
    // clear pulse limits in cycles, shortened in simulation
    parameter [31:0] CLR_MIN_A_CYC = `PCM_CLR_MIN_A_MS * `PCM_CYC_PER_MS,
    parameter [31:0] CLR_MIN_B_CYC = `PCM_CLR_MIN_B_MS * `PCM_CYC_PER_MS,
    parameter [31:0] CLR_MAX_CYC = `PCM_CLR_MAX_MS * `PCM_CYC_PER_MS
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // press contacts and pins
    input wire upper_position_contact,
    input wire lower_position_contact,
    input wire overrun_contact,
    input wire clear_in,
    input wire permit_in,
    // drive command from internal logic
    input wire drive_cmd,
    // outputs to press control
    output reg permit_q,
    output reg upstroke_q,
    output reg upper_zone_q,
    output reg clear_needed_q,
    output reg seq_fault_q,
    output reg ovr_fault_q,
    output reg fault_flag_q
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // edge of a sampled level against its previous sample
    function rise;
        input now_v;
        input prev_v;
        rise = now_v & ~prev_v;
    endfunction

    function fall;
        input now_v;
        input prev_v;
        fall = ~now_v & prev_v;
    endfunction

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    reg [`PCM_CTRL_W-1:0] ctrl_q; // software control bits
    reg wr_pend_q; // write data phase pending
    reg [31:0] wr_addr_q; // address of pending write
    wire [`PCM_NSYNC-1:0] pins_s; // synchronised pins
    wire up_s; // upper contact
    wire lo_s; // lower contact
    wire ov_s; // overrun contact
    wire prm_s; // permit pin
    reg up_p_q; // previous samples
    reg lo_p_q;
    reg ov_p_q;
    reg drv_p_q;
    reg act_p_q; // monitoring active last cycle
    reg [1:0] lo_cnt_q; // lower rises this stroke
    reg arm_q; // upstroke allowed this cycle
    reg lo_fell_q; // a lower fall seen this stroke
    reg drv_ok_q; // drive rose since upper zone rose
    wire clr_ok; // accepted clear pulse
    wire [31:0] clr_min; // selected minimum
    wire run; // program executing
    wire ovr_en; // overrun checking on
    wire mode02; // 0-2 lower edges mode
    wire act; // checks active
    wire start; // first active cycle
    wire up_r;
    wire up_f;
    wire lo_r;
    wire lo_f;
    wire ov_f;
    wire drv_r;
    reg seq_err; // sequence deviation this cycle
    reg ovr_err; // late drive this cycle
    wire addr_ok; // bus request taken
    wire [`PCM_STAT_W-1:0] stat; // status word

    // ------------------------------------------------------------
    // input sampling
    // ------------------------------------------------------------
    // pins pass two flops; drive_cmd is an internal flag, no sync
    pcm_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in({permit_in, clear_in, overrun_contact,
                   lower_position_contact, upper_position_contact}),
        .sync_out(pins_s)
    );

    assign up_s = pins_s[`PCM_S_UP];
    assign lo_s = pins_s[`PCM_S_LO];
    assign ov_s = pins_s[`PCM_S_OV];
    assign prm_s = pins_s[`PCM_S_PRM];

    // edges from sample against previous sample
    assign up_r = rise(up_s, up_p_q);
    assign up_f = fall(up_s, up_p_q);
    assign lo_r = rise(lo_s, lo_p_q);
    assign lo_f = fall(lo_s, lo_p_q);
    assign ov_f = fall(ov_s, ov_p_q);
    assign drv_r = rise(drive_cmd, drv_p_q);

    // ------------------------------------------------------------
    // clear pulse
    // ------------------------------------------------------------
    assign clr_min = ctrl_q[`PCM_C_MIN350] ? CLR_MIN_B_CYC :
                     CLR_MIN_A_CYC;

    pcm_clrpulse u_clr (
        .hclk(hclk),
        .hresetn(hresetn),
        .level(pins_s[`PCM_S_CLR]),
        .min_cyc(clr_min),
        .max_cyc(CLR_MAX_CYC),
        .valid(clr_ok)
    );

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    assign run = ctrl_q[`PCM_C_RUN];
    assign ovr_en = ctrl_q[`PCM_C_OVREN];
    assign mode02 = ctrl_q[`PCM_C_MODE02];
    // checks run only with program, permit and no fault
    assign act = run & prm_s & ~seq_fault_q & ~ovr_fault_q;
    assign start = act & ~act_p_q;

    // ------------------------------------------------------------
    // sequence checks
    // ------------------------------------------------------------
    always @*
    begin
        seq_err = 1'b0;
        ovr_err = 1'b0;
        if (act)
        begin
            // overrun and upper contact never both low
            if (ovr_en && !ov_s && !up_s)
                seq_err = 1'b1;
            // one-edge mode: lower contact must be low when upper rises
            if (up_r && lo_s && !mode02)
                seq_err = 1'b1;
            // one-edge mode: upper leaves only after one rise
            if (up_f && arm_q && !mode02 &&
                lo_cnt_q != `PCM_CNT_ONE)
                seq_err = 1'b1;
            // a second rise in one-edge mode
            if (lo_r && up_s && !mode02 &&
                lo_cnt_q == `PCM_CNT_ONE)
                seq_err = 1'b1;
            // a third rise in 0-2 mode
            if (lo_r && up_s && mode02 &&
                lo_cnt_q == `PCM_CNT_TWO)
                seq_err = 1'b1;
            // drive must have risen or be high at overrun end
            if (ovr_en && ov_f && !drv_ok_q && !drive_cmd)
                ovr_err = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // stroke tracking
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            up_p_q <= 1'b0;
            lo_p_q <= 1'b0;
            ov_p_q <= 1'b0;
            drv_p_q <= 1'b0;
            act_p_q <= 1'b0;
            lo_cnt_q <= `PCM_CNT_ZERO;
            arm_q <= 1'b0;
            lo_fell_q <= 1'b0;
            drv_ok_q <= 1'b0;
        end
        else
        begin
            up_p_q <= up_s;
            lo_p_q <= lo_s;
            ov_p_q <= ov_s;
            drv_p_q <= drive_cmd;
            act_p_q <= act;
            if (!act)
            begin
                // idle: forget the stroke
                lo_cnt_q <= `PCM_CNT_ZERO;
                lo_fell_q <= 1'b0;
                drv_ok_q <= 1'b0;
                arm_q <= 1'b0;
            end
            else
            begin
                // lower high at start blanks upstroke until upper falls
                if (start)
                    arm_q <= ~lo_s;
                else if (up_f)
                    arm_q <= 1'b1;
                // a new stroke begins when upper rises
                if (up_r)
                begin
                    lo_cnt_q <= `PCM_CNT_ZERO;
                    lo_fell_q <= 1'b0;
                    drv_ok_q <= drv_r;
                end
                else
                begin
                    // bottom arrival only while upper is high
                    if (lo_r && up_s &&
                        lo_cnt_q != `PCM_CNT_MAX)
                        lo_cnt_q <= lo_cnt_q + `PCM_CNT_ONE;
                    if (lo_f)
                        lo_fell_q <= 1'b1;
                    if (drv_r)
                        drv_ok_q <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // outputs and fault latches
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            permit_q <= 1'b0;
            upstroke_q <= 1'b0;
            upper_zone_q <= 1'b0;
            clear_needed_q <= 1'b0;
            seq_fault_q <= 1'b0;
            ovr_fault_q <= 1'b0;
            fault_flag_q <= 1'b0;
        end
        else if (!run)
        begin
            // program stopped: whole state cleared
            permit_q <= 1'b0;
            upstroke_q <= 1'b0;
            upper_zone_q <= 1'b0;
            clear_needed_q <= 1'b0;
            seq_fault_q <= 1'b0;
            ovr_fault_q <= 1'b0;
            fault_flag_q <= 1'b0;
        end
        else
        begin
            upper_zone_q <= up_s;
            // new faults win over a clear in the same cycle
            if (seq_err)
                seq_fault_q <= 1'b1;
            else if (clr_ok && ctrl_q[`PCM_C_CLREN])
                seq_fault_q <= 1'b0;
            if (ovr_err)
                ovr_fault_q <= 1'b1;
            else if (clr_ok && ctrl_q[`PCM_C_CLREN])
                ovr_fault_q <= 1'b0;
            if (seq_err || ovr_err)
            begin
                clear_needed_q <= 1'b1;
                fault_flag_q <= ctrl_q[`PCM_C_FLAGEN];
            end
            else
            begin
                clear_needed_q <= seq_fault_q | ovr_fault_q;
                fault_flag_q <= ctrl_q[`PCM_C_FLAGEN] &
                                (seq_fault_q | ovr_fault_q);
                if (clr_ok && ctrl_q[`PCM_C_CLREN])
                begin
                    clear_needed_q <= 1'b0;
                    fault_flag_q <= 1'b0;
                end
            end
            // permit needs pin high and no fault
            permit_q <= act & ~seq_err & ~ovr_err;
            // upstroke indicator
            if (!act || seq_err || up_r)
                upstroke_q <= 1'b0;
            else if (lo_f)
                upstroke_q <= 1'b0;
            else if (lo_r && up_s && arm_q && !lo_fell_q &&
                     lo_cnt_q == `PCM_CNT_ZERO)
                upstroke_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------
    assign addr_ok = hsel & hready & htrans[`PCM_HTRANS_BUSY_BIT];

    // status word: outputs then synchronised contacts
    assign stat = {pins_s, permit_q, upstroke_q, upper_zone_q,
                   clear_needed_q, seq_fault_q, ovr_fault_q,
                   fault_flag_q, run};

    // zero wait states, always okay, read data in data phase
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= `PCM_ZERO32;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= `PCM_ZERO32;
            ctrl_q <= `PCM_CTRL_RST;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            // apply write data of the previous address phase
            if (wr_pend_q && wr_addr_q == `PCM_ADDR_CTRL)
                ctrl_q <= hwdata[`PCM_CTRL_W-1:0];
            wr_pend_q <= addr_ok & hwrite;
            if (addr_ok)
                wr_addr_q <= haddr & `PCM_ADDR_MASK;
            // read mux, unmapped reads as zero
            hrdata <= `PCM_ZERO32;
            if (addr_ok && !hwrite)
            begin
                if ((haddr & `PCM_ADDR_MASK) == `PCM_ADDR_CTRL)
                    hrdata <= {{(32-`PCM_CTRL_W){1'b0}}, ctrl_q};
                else if ((haddr & `PCM_ADDR_MASK) == `PCM_ADDR_STAT)
                    hrdata <= {{(32-`PCM_STAT_W){1'b0}}, stat};
            end
        end
    end

endmodule // pcm_monitor

`default_nettype wire

// ---- tb/pcm_monitor_props.sv ----
// port-level checks for the press contact sequence monitor
`default_nettype none

module pcm_monitor_chk (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus signals
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // contacts and pins
    input wire logic lower_position_contact,
    input wire logic upper_position_contact,
    input wire logic clear_in,
    input wire logic permit_in,
    // press outputs
    input wire logic permit_q,
    input wire logic upstroke_q,
    input wire logic clear_needed_q,
    input wire logic seq_fault_q,
    input wire logic ovr_fault_q,
    input wire logic fault_flag_q
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic lo_prev_q; // lower contact one cycle back
    logic [3:0] lo_gap_q; // cycles since a lower contact rise
    logic [3:0] cause_q; // cycles since a clear level or a write
    // age counters, saturating so old causes never look fresh
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lo_prev_q <= 1'b0;
            lo_gap_q <= 4'hf;
            cause_q <= 4'hf;
        end
        else
        begin
            lo_prev_q <= lower_position_contact;
            if (lower_position_contact && !lo_prev_q)
                lo_gap_q <= 4'h0;
            else if (lo_gap_q != 4'hf)
                lo_gap_q <= lo_gap_q + 4'h1;
            if (clear_in || (hsel && hready && htrans[1] && hwrite))
                cause_q <= 4'h0;
            else if (cause_q != 4'hf)
                cause_q <= cause_q + 4'h1;
        end
    end
    chk_bus_ready: assert property (hreadyout)
        else $error("wait state");
    chk_bus_okay: assert property (!hresp)
        else $error("error response");
    chk_rdata_idle: assert property (
        !(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0)
        else $error("stale read data");
    chk_seq_permit: assert property (
        seq_fault_q && $past(seq_fault_q) |-> !permit_q && clear_needed_q)
        else $error("seq fault outputs");
    chk_ovr_permit: assert property (
        $rose(ovr_fault_q) |-> ##[0:1] (!permit_q && clear_needed_q))
        else $error("ovr fault outputs");
    chk_flag_cause: assert property (
        $rose(fault_flag_q) |-> seq_fault_q || ovr_fault_q)
        else $error("fault flag without a fault");
    chk_fault_release: assert property (
        $fell(seq_fault_q) || $fell(ovr_fault_q) || $fell(clear_needed_q)
        |-> cause_q < 4'h8)
        else $error("release without cause");
    chk_up_cause: assert property (
        $rose(upstroke_q) |-> lo_gap_q < 4'h8 && upper_position_contact)
        else $error("upstroke uncaused");
    chk_up_drop: assert property (
        $fell(lower_position_contact) |-> ##[1:6] !upstroke_q)
        else $error("upstroke kept after lower fall");
    chk_permit_off: assert property (
        !permit_in [*5] |=> !permit_q)
        else $error("permit while held");
endmodule // pcm_monitor_chk

bind pcm_monitor pcm_monitor_chk u_chk (.*);
`default_nettype wire

// ---- tb/pcm_press_model.sv ----
// press contacts and drive command model for the monitor bench
`default_nettype none

module pcm_press_model (
    // clock
    input wire logic hclk,
    // contacts and drive command
    output logic upper,
    output logic lower,
    output logic overrun,
    output logic drive
);
    timeunit 1ns;
    timeprecision 1ns;
    // press parked at top, drive flag from internal logic
    initial
    begin
        upper = 1'b1;
        lower = 1'b0;
        overrun = 1'b0;
        drive = 1'b1;
    end
    // wait a number of clock edges
    task automatic step(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // one stroke: nlow bottom pulses, bad drops overrun early
    task automatic stroke(input int nlow, input logic bad, input logic late);
        step(1);
        drive <= !late;
        repeat (nlow)
        begin
            lower <= 1'b1;
            step(8);
            lower <= 1'b0;
            step(8);
        end
        overrun <= 1'b1;
        step(8);
        upper <= 1'b0;
        step(8);
        if (bad)
            overrun <= 1'b0;
        step(8);
        upper <= 1'b1;
        step(8);
        overrun <= 1'b0;
        step(8);
        drive <= 1'b1;
    endtask
endmodule // pcm_press_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the press contact sequence monitor
`include "pcm_consts.vh"
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ---------------------------------------------------------
    // signals and instances
    // ---------------------------------------------------------
    logic hclk, hresetn, hsel, hwrite, clear_in, permit_in;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, rd;
    wire [31:0] hrdata;
    wire hrdy, hresp, up_c, lo_c, ov_c, drv;
    wire permit_q, upstroke_q, zone_q, need_q, seq_q, ovr_q, flag_q;
    int failures, comparisons;
    pcm_press_model u_press (.hclk(hclk), .upper(up_c), .lower(lo_c),
        .overrun(ov_c), .drive(drv));
    pcm_monitor #(.CLR_MIN_A_CYC(32'd10), .CLR_MIN_B_CYC(32'd35),
        .CLR_MAX_CYC(32'd300)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
        .upper_position_contact(up_c), .lower_position_contact(lo_c),
        .overrun_contact(ov_c), .clear_in(clear_in), .permit_in(permit_in),
        .drive_cmd(drv), .permit_q(permit_q), .upstroke_q(upstroke_q),
        .upper_zone_q(zone_q), .clear_needed_q(need_q), .seq_fault_q(seq_q),
        .ovr_fault_q(ovr_q), .fault_flag_q(flag_q));
    // ---------------------------------------------------------
    // helpers
    // ---------------------------------------------------------
    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // one single-word transfer, held until hready is seen
    task automatic bus(input logic w, input logic [31:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hrdy !== 1'b1);
        q = hrdata;
    endtask
    // stop, then run with a fresh control word
    task automatic start(input logic [31:0] c);
        bus(1'b1, `PCM_ADDR_CTRL, 32'h0, rd);
        bus(1'b1, `PCM_ADDR_CTRL, c, rd);
        cyc(4);
    endtask
    // fault outputs, permit and flag against expected faults
    task automatic chk_state(input logic s, input logic o);
        chk1(seq_q, s);
        chk1(ovr_q, o);
        chk1(permit_q, !(s || o));
        chk1(need_q, s || o);
        chk1(flag_q, s || o);
        chk1(zone_q, 1'b1);
    endtask
    // ---------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------
    task automatic t_regs();
        bus(1'b0, `PCM_ADDR_CTRL, 32'h0, rd);
        chk32(rd, 32'h0);
        bus(1'b1, 32'h0000_0080, 32'h0000_003f, rd);
        bus(1'b0, 32'h0000_0080, 32'h0, rd);
        chk32(rd, 32'h0);
        bus(1'b0, `PCM_ADDR_CTRL, 32'h0, rd);
        chk32(rd, 32'h0);
    endtask
    task automatic t_single();
        start(32'h33);
        bus(1'b0, `PCM_ADDR_CTRL, 32'h0, rd);
        chk32(rd, 32'h33);
        fork
            u_press.stroke(1, 1'b0, 1'b0);
            begin
                cyc(8);
                chk1(upstroke_q, 1'b1);
            end
        join
        cyc(8);
        chk_state(1'b0, 1'b0);
        u_press.stroke(0, 1'b0, 1'b0);
        cyc(8);
        chk_state(1'b1, 1'b0);
    endtask
    // short, long, short for 350 mode, then a valid pulse
    task automatic t_clear();
        int n [4] = '{5, 400, 20, 40};
        logic [31:0] c [4] = '{32'h33, 32'h33, 32'h3b, 32'h3b};
        logic e [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, `PCM_ADDR_CTRL, c[i], rd);
            clear_in <= 1'b1;
            cyc(n[i]);
            clear_in <= 1'b0;
            cyc(10);
            chk1(seq_q, e[i]);
        end
        chk_state(1'b0, 1'b0);
    endtask
    task automatic t_mode02();
        start(32'h37);
        u_press.stroke(0, 1'b0, 1'b0);
        cyc(8);
        chk_state(1'b0, 1'b0);
        fork
            u_press.stroke(2, 1'b0, 1'b0);
            begin
                cyc(8);
                chk1(upstroke_q, 1'b1);
                cyc(16);
                chk1(upstroke_q, 1'b0);
            end
        join
        cyc(8);
        chk_state(1'b0, 1'b0);
    endtask
    // early overrun drop, same with checks off, late drive
    task automatic t_overrun();
        logic [31:0] c [3] = '{32'h33, 32'h13, 32'h33};
        logic b [3] = '{1'b1, 1'b1, 1'b0};
        logic l [3] = '{1'b0, 1'b0, 1'b1};
        logic s [3] = '{1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 3; i++)
        begin
            start(c[i]);
            u_press.stroke(1, b[i], l[i]);
            cyc(8);
            chk_state(s[i], l[i]);
        end
    endtask
    task automatic t_permit();
        start(32'h33);
        permit_in <= 1'b0;
        cyc(8);
        chk1(permit_q, 1'b0);
        u_press.stroke(0, 1'b0, 1'b0);
        cyc(8);
        chk1(seq_q, 1'b0);
        permit_in <= 1'b1;
        cyc(8);
        chk1(permit_q, 1'b1);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ---------------------------------------------------------
    // clock, main sequence and watchdog
    // ---------------------------------------------------------
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        clear_in = 1'b0;
        permit_in = 1'b1;
        failures = 0;
        comparisons = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_single();
        t_clear();
        t_mode02();
        t_overrun();
        t_permit();
        print_verdict();
    end
    // cut a hang short well beyond the expected run
    initial
    begin
        #200000;
        failures++;
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
